// ### tpsync_defs.svh
// constants of the timer prescaler and external clock synchronizer
`ifndef TPSYNC_DEFS_SVH
`define TPSYNC_DEFS_SVH
`define TP_DATA_W     8
`define TP_ADDR_W     4
`define TP_PSC_W      8
`define TP_A_SETUP    4'h0
`define TP_A_COUNT    4'h1
`define TP_A_WDCLR    4'h2
`define TP_A_STAT     4'h3
`define TP_SETUP_RST  6'h3F
`define TP_ZERO8      8'h00
`define TP_ONE8       8'h01
`define TP_RATIO_ONE  3'h1
`define TP_RATIO_NONE 3'h0
`define TP_CLK_MHZ    125
`define TP_TOSC_NS    8
`define TP_INC_MIN_TOSC 3
`define TP_INC_MAX_TOSC 7
`endif

// ### tpsync_pkg.sv
// types shared by the timer prescaler and synchronizer
`default_nettype none
`include "tpsync_defs.svh"
package tpsync_pkg;
  // instruction phases, gray coded
  typedef enum logic [1:0] {
    TPS_Q1 = 2'h0,
    TPS_Q2 = 2'h1,
    TPS_Q3 = 2'h3,
    TPS_Q4 = 2'h2
  } tpsync_phase_t;

  typedef struct packed {
    logic [`TP_ADDR_W-1:0] addr;
    logic [`TP_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } tpsync_bus_t;

  typedef struct packed {
    logic       clk_src;
    logic       edge_sel;
    logic       assign_wd;
    logic [2:0] ratio;
  } tpsync_setup_t;

  typedef struct packed {
    tpsync_phase_t ph;
    logic          q2;
    logic          q4;
  } tpsync_ph_st_t;

  typedef struct packed {
    tpsync_setup_t         setup;
    logic [`TP_DATA_W-1:0] count;
    logic [`TP_DATA_W-1:0] wdt_base;
    logic                  sel;
    logic                  samp;
    logic                  samp_old;
    logic                  inc;
    logic                  wd_bit;
    logic                  wdt_to;
    logic                  wrap;
    logic [`TP_DATA_W-1:0] rdata;
  } tpsync_st_t;
endpackage : tpsync_pkg
`default_nettype wire

// ### tpsync_phase.sv
// four-phase instruction cycle generator with Q2 and Q4 strobes
`default_nettype none
module tpsync_phase
  import tpsync_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  output logic      q2,
  output logic      q4
);
  tpsync_ph_st_t st_q;
  tpsync_ph_st_t st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q.ph)
      TPS_Q1: st_d.ph = TPS_Q2;
      TPS_Q2: st_d.ph = TPS_Q3;
      TPS_Q3: st_d.ph = TPS_Q4;
      TPS_Q4: st_d.ph = TPS_Q1;
    endcase
    // strobes are registered so they stand exactly in their phase
    st_d.q2 = (st_d.ph == TPS_Q2);
    st_d.q4 = (st_d.ph == TPS_Q4);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '{ph: TPS_Q1, q2: 1'b0, q4: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign q2 = st_q.q2;
  assign q4 = st_q.q4;
endmodule : tpsync_phase
`default_nettype wire

// ### tpsync_psc.sv
// shared prescaler counter, clear wins over count
`default_nettype none
`include "tpsync_defs.svh"
module tpsync_psc #(
  parameter int W = `TP_PSC_W
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic      [W-1:0] cnt
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = '0;
    end else if (inc) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt = cnt_q;
endmodule : tpsync_psc
`default_nettype wire

// ### tpsync_top.sv
// timer prescaler, watchdog postscaler and external clock synchronizer
//
// The address map and the strobed register port are this design's own decisions.
`default_nettype none
`include "tpsync_defs.svh"
module tpsync_top
  import tpsync_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire tpsync_bus_t           bus,
  input  wire logic                  timer_ext_clock_pin,
  input  wire logic                  wdt_tick,
  output logic      [`TP_DATA_W-1:0] rdata,
  output logic      [`TP_DATA_W-1:0] timer_count,
  output logic                       wdt_timeout,
  output logic                       timer_wrap
);
  // ----------------------------------------------------------------
  // timing figures
  // ----------------------------------------------------------------
  localparam int CLK_NS  = 1000 / `TP_CLK_MHZ;
  localparam int INC_MIN =
    (`TP_INC_MIN_TOSC * `TP_TOSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int INC_MAX = (`TP_INC_MAX_TOSC * `TP_TOSC_NS) / CLK_NS;
  localparam int WIN_LO  = 2;
  localparam int WIN_HI  = 5;

  tpsync_st_t            st_q;
  tpsync_st_t            st_d;
  logic                  q2;
  logic                  q4;
  logic [`TP_PSC_W-1:0]  psc_cnt;
  logic                  psc_clr;
  logic                  psc_inc;
  logic                  wr_setup;
  logic                  wr_count;
  logic                  wr_wdclr;
  logic                  sel_lvl;
  logic                  ext_evt;
  logic                  tmr_evt;
  logic                  wdt_ovf;
  logic                  sync_src;
  logic                  direct_inc;
  logic                  wd_bit;
  logic [`TP_PSC_W-1:0]  wd_mask;

  // ----------------------------------------------------------------
  // phase clocks and the shared counter
  // ----------------------------------------------------------------
  tpsync_phase u_phase (
    .mclk (mclk),
    .rst  (rst),
    .q2   (q2),
    .q4   (q4)
  );

  tpsync_psc #(
    .W (`TP_PSC_W)
  ) u_psc (
    .mclk (mclk),
    .rst  (rst),
    .clr  (psc_clr),
    .inc  (psc_inc),
    .cnt  (psc_cnt)
  );

  // ----------------------------------------------------------------
  // decode and event sources
  // ----------------------------------------------------------------
  assign wr_setup = bus.wr && (bus.addr == `TP_A_SETUP);
  assign wr_count = bus.wr && (bus.addr == `TP_A_COUNT);
  assign wr_wdclr = bus.wr && (bus.addr == `TP_A_WDCLR);

  // inverting by the select makes the chosen edge a rising one
  assign sel_lvl = timer_ext_clock_pin ^ st_q.setup.edge_sel;
  assign ext_evt = sel_lvl && !st_q.sel;
  assign tmr_evt = st_q.setup.clk_src ? ext_evt : q4;
  assign wdt_ovf = wdt_tick && (st_q.wdt_base == '1);

  // the counter has a single owner at any time
  assign psc_inc = st_q.setup.assign_wd ? wdt_ovf : tmr_evt;
  assign psc_clr = (wr_count && !st_q.setup.assign_wd)
                || (wr_wdclr && st_q.setup.assign_wd);

  // bit n toggles every 2^n events: divide by 2^(n+1), 50% duty
  always_comb begin
    if (!st_q.setup.assign_wd) begin
      sync_src = psc_cnt[st_q.setup.ratio];
    end else begin
      sync_src = st_q.setup.clk_src && sel_lvl;
    end
  end

  // internal clock without prescaler counts each instruction cycle
  assign direct_inc = st_q.setup.assign_wd && !st_q.setup.clk_src && q4;

  // time-out on the overflow that completes 2^n of them since the clear;
  // a bit edge would fire half way or on the clear itself
  assign wd_mask = ~({`TP_PSC_W{1'b1}} << st_q.setup.ratio);
  assign wd_bit  = wdt_ovf && (&(psc_cnt | ~wd_mask));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.rdata = `TP_ZERO8;
    st_d.wrap  = 1'b0;
    st_d.sel   = sel_lvl;

    // setup may be rewritten at any time, no reset needed
    if (wr_setup) begin
      st_d.setup = bus.wdata[5:0];
    end

    // two looks per instruction cycle
    if (q2 || q4) begin
      st_d.samp = sync_src;
    end
    st_d.samp_old = st_q.samp;
    // extra stage keeps the edge-to-count delay inside the window
    st_d.inc = (st_q.samp && !st_q.samp_old) || direct_inc;

    if (wr_count) begin
      st_d.count = bus.wdata;
    end else if (st_q.inc) begin
      st_d.count = st_q.count + `TP_ONE8;
      st_d.wrap  = (st_q.count == '1);
    end

    if (wr_wdclr) begin
      st_d.wdt_base = `TP_ZERO8;
    end else if (wdt_tick) begin
      st_d.wdt_base = st_q.wdt_base + `TP_ONE8;
    end

    // watchdog postscaler: 2^n overflows per time-out
    st_d.wd_bit = wd_bit;
    if (!st_q.setup.assign_wd) begin
      st_d.wdt_to = wdt_ovf;
    end else if (st_q.setup.ratio == `TP_RATIO_NONE) begin
      st_d.wdt_to = wdt_ovf;
    end else begin
      st_d.wdt_to = wd_bit;
    end

    // the prescaler itself has no address
    if (bus.rd) begin
      unique case (bus.addr)
        `TP_A_SETUP: st_d.rdata = {2'h0, st_q.setup};
        `TP_A_COUNT: st_d.rdata = st_q.count;
        `TP_A_STAT:  st_d.rdata = {6'h00, st_q.setup.assign_wd,
                                   st_q.samp};
        default:     st_d.rdata = `TP_ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q          <= '0;
      st_q.setup    <= `TP_SETUP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata       = st_q.rdata;
  assign timer_count = st_q.count;
  assign wdt_timeout = st_q.wdt_to;
  assign timer_wrap  = st_q.wrap;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_rise_seen;
    $rose(st_q.samp) && !wr_count ##1 !wr_count;
  endsequence

  sequence s_pin_edge;
    st_q.setup.assign_wd && st_q.setup.clk_src && !st_q.samp
      && $rose(sync_src) && !wr_setup ##1 sync_src && !wr_count;
  endsequence

  sequence s_wr_timer_count;
    wr_count && !st_q.setup.assign_wd;
  endsequence

  a_psc_reset_zero: assert property (
    $fell(rst) |-> psc_cnt == `TP_ZERO8)
    else $error("prescaler not zero after reset");

  a_count_wr_clr: assert property (
    s_wr_timer_count |=> psc_cnt == `TP_ZERO8)
    else $error("timer write did not clear prescaler");

  a_wd_clear_both: assert property (
    wr_wdclr && st_q.setup.assign_wd
      |=> psc_cnt == `TP_ZERO8 && st_q.wdt_base == `TP_ZERO8)
    else $error("watchdog clear missed a counter");

  a_samp_on_phase: assert property (
    $changed(st_q.samp) |-> $past(q2) || $past(q4))
    else $error("sample taken outside Q2 and Q4");

  a_inc_pipe: assert property (
    s_rise_seen |=> timer_count == $past(timer_count, 2) + `TP_ONE8)
    else $error("count did not follow synchronized edge");

  a_pin_to_count: assert property (
    s_pin_edge |-> ##[WIN_LO:WIN_HI] $changed(timer_count))
    else $error("pin edge not counted in time");

  a_raw_source: assert property (
    st_q.setup.assign_wd && st_q.setup.clk_src
      |-> sync_src == (timer_ext_clock_pin ^ st_q.setup.edge_sel))
    else $error("raw pin not fed to synchronizer");

  a_one_owner: assert property (
    st_q.setup.assign_wd && !wdt_ovf |=> $stable(psc_cnt)
      || $past(psc_clr))
    else $error("timer events reached watchdog prescaler");

  a_setup_take: assert property (
    wr_setup |=> st_q.setup.assign_wd == $past(bus.wdata[3])
      && st_q.setup.ratio == $past(bus.wdata[2:0]))
    else $error("setup write not applied");

  a_wd_ratio_one: assert property (
    st_q.setup.assign_wd && st_q.setup.ratio == `TP_RATIO_NONE
      && wdt_ovf && !wr_setup |=> wdt_timeout)
    else $error("1:1 watchdog time-out missing");

  a_inc_window: assert property (
    $changed(timer_count) |-> $past(st_q.inc) || $past(wr_count))
    else $error("count moved without increment or write");
endmodule : tpsync_top
`default_nettype wire

// ### tpsync_ext_src.sv
// external clock source model driving the timer pin
`default_nettype none
module tpsync_ext_src (
  input  wire logic mclk,
  output var  logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle low between bursts; callers never ask for h below two
  initial pin = 1'b0;
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      pin <= 1'b1;
      repeat (h) @(posedge mclk);
      pin <= 1'b0;
      repeat (h) @(posedge mclk);
    end
  endtask : pulses
endmodule : tpsync_ext_src
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the timer prescaler and synchronizer
`default_nettype none
`include "tpsync_defs.svh"
module tb_top import tpsync_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, pin, wdt_tick, wdt_timeout, timer_wrap;
  tpsync_bus_t bus;
  logic [7:0]  rdata, timer_count;
  int          fails = 0, n_compared = 0, n_to = 0, n_wrap = 0;

  tpsync_top u_dut (
    .mclk(mclk), .rst(rst), .bus(bus), .timer_ext_clock_pin(pin),
    .wdt_tick(wdt_tick), .rdata(rdata), .timer_count(timer_count),
    .wdt_timeout(wdt_timeout), .timer_wrap(timer_wrap));
  tpsync_ext_src u_src (.mclk(mclk), .pin(pin));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // pulse outputs last one cycle, so count them as they pass
  always @(posedge mclk) begin
    if (wdt_timeout === 1'b1)
      n_to++;
    if (timer_wrap === 1'b1)
      n_wrap++;
  end

  // ----
  // bus and check tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                      input string nm);
    logic [7:0] v;
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 v = rdata;
    @(posedge mclk);
    chk(nm, v, e);
  endtask : rchk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  task automatic ticks(input int n);
    repeat (n) begin
      wdt_tick <= 1'b1;
      @(posedge mclk);
      wdt_tick <= 1'b0;
      @(posedge mclk);
    end
  endtask : ticks

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rchk(`TP_A_SETUP, 8'h3F, "setup");
    rchk(`TP_A_COUNT, 8'h00, "count");
    rchk(4'hF, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_pin;
    int         k;
    logic [7:0] c;
    wr(`TP_A_SETUP, 8'h28);
    wr(`TP_A_COUNT, 8'hFE);
    u_src.pulses(3, 2);
    wt(10);
    rchk(`TP_A_COUNT, 8'h01, "rise cnt");
    chk("wrap", 8'(n_wrap), 8'h01);
    c = timer_count;
    k = 0;
    fork
      u_src.pulses(1, 3);
      while (timer_count === c && k < 12) begin
        @(posedge mclk);
        #1 k++;
      end
    join
    @(posedge mclk);
    chk("delay", {7'h0, k inside {[3:7]}}, 8'h01);
    // edge select flip may add one count, so clear after it settles
    wr(`TP_A_SETUP, 8'h38);
    wt(8);
    wr(`TP_A_COUNT, 8'h00);
    u_src.pulses(2, 2);
    wt(10);
    rchk(`TP_A_COUNT, 8'h02, "fall cnt");
  endtask : t_pin

  task automatic t_ratio;
    wr(`TP_A_WDCLR, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(`TP_A_SETUP, 8'h20 | 8'(n));
      wr(`TP_A_COUNT, 8'h00);
      u_src.pulses(2 << n, 2);
      wt(10);
      rchk(`TP_A_COUNT, 8'h01, "one per");
      u_src.pulses(2 << n, 2);
      wt(10);
      rchk(`TP_A_COUNT, 8'h02, "two per");
    end
    rchk(`TP_A_STAT, 8'h00, "stat");
  endtask : t_ratio

  task automatic t_clr;
    wr(`TP_A_SETUP, 8'h21);
    wr(`TP_A_COUNT, 8'h00);
    u_src.pulses(1, 2);
    wr(`TP_A_COUNT, 8'h10);
    u_src.pulses(1, 2);
    wt(10);
    rchk(`TP_A_COUNT, 8'h10, "psc clr");
    u_src.pulses(1, 2);
    wt(10);
    rchk(`TP_A_COUNT, 8'h11, "psc next");
    // internal clock, no prescaler: one count per instruction cycle
    wr(`TP_A_SETUP, 8'h08);
    wr(`TP_A_COUNT, 8'h00);
    wt(40);
    chk("int rate", {7'h0, timer_count inside {[9:11]}}, 8'h01);
  endtask : t_clr

  task automatic t_wd;
    int t0;
    wr(`TP_A_WDCLR, 8'h00);
    wr(`TP_A_COUNT, 8'h00);
    wr(`TP_A_SETUP, 8'h2F);
    wr(`TP_A_WDCLR, 8'h00);
    wr(`TP_A_SETUP, 8'h28);
    t0 = n_to;
    ticks(200);
    wr(`TP_A_WDCLR, 8'h00);
    ticks(255);
    wt(3);
    chk("wd early", 8'(n_to - t0), 8'h00);
    ticks(1);
    wt(3);
    chk("wd out", 8'(n_to - t0), 8'h01);
    wr(`TP_A_SETUP, 8'h29);
    wr(`TP_A_WDCLR, 8'h00);
    t0 = n_to;
    ticks(256);
    wt(3);
    chk("wd half", 8'(n_to - t0), 8'h00);
    ticks(768);
    wt(3);
    chk("wd ratio", 8'(n_to - t0), 8'h02);
    rchk(`TP_A_STAT, 8'h02, "stat wd");
  endtask : t_wd

  task automatic close_out;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    rst = 1'b1;
    bus = '0;
    wdt_tick = 1'b0;
    wt(5);
    rst <= 1'b0;
    t_reset();
    t_pin();
    t_ratio();
    t_clr();
    t_wd();
    close_out();
  end

  initial begin
    wt(30000);
    fails++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
